/* File: hw/pdwg_apb_master.sv */
// apb master toward the device register interface
// assumes one request at a time; holds select, write, address and data until pready closes the access, raising penable after setup
`timescale 1ns/1ps
module pdwg_apb_master import pdwg_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req_valid,
  input  wire pdwg_req_t   req,
  output logic             req_ready,
  output logic             done,
  output logic      [31:0] rdata,
  output pdwg_apb_t        m,
  input  wire logic        m_pready,
  input  wire logic [31:0] m_prdata
);
  typedef struct packed {
    pdwg_apb_t   m;
    logic        done;
    logic [31:0] rdata;
  } pdwg_ms_t;
  pdwg_ms_t r, next_r;

  assign req_ready = !r.m.psel;
  assign done      = r.done;
  assign rdata     = r.rdata;
  assign m         = r.m;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (!r.m.psel && req_valid) begin
      next_r.m = '{psel: 1'b1, penable: 1'b0, pwrite: req.write, paddr: req.addr,
                   pwdata: req.wdata};
    end else if (r.m.psel && !r.m.penable) begin
      next_r.m.penable = 1'b1;
    end else if (r.m.psel && m_pready) begin
      next_r.m.psel    = 1'b0;
      next_r.m.penable = 1'b0;
      next_r.done      = 1'b1;
      if (!r.m.pwrite) begin
        next_r.rdata = m_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  hold_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    (m.psel && !m_pready) |=> $stable(m.paddr) && $stable(m.pwdata) && m.psel)
    else $error("apb request changed before pready");
endmodule

/* File: hw/pdwg_apb_slave.sv */
// apb slave with the controller's own command and status registers
// assumes apb3 signalling on pclk; always ready, read data taken in the setup cycle
`timescale 1ns/1ps
module pdwg_apb_slave import pdwg_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pdwg_stat_t  stat,
  output pdwg_ctrl_t       ctrl
);
  typedef struct packed {
    pdwg_ctrl_t  ctrl;
    logic [31:0] prdata;
    logic        pslverr;
  } pdwg_sl_t;
  pdwg_sl_t r, next_r;
  logic setup;
  logic wr;

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign prdata  = r.prdata;
  assign pslverr = r.pslverr;
  assign ctrl    = r.ctrl;

  always_comb begin
    next_r = r;
    next_r.ctrl.go    = 1'b0;
    next_r.ctrl.abort = 1'b0;
    if (setup) begin
      next_r.pslverr = 1'b0;
      next_r.prdata  = 32'h0000_0000;
      case (paddr)
        REG_CTRL:    next_r.prdata = 32'h0000_0000;
        REG_SRC_EN:  next_r.prdata = {19'h0, r.ctrl.src_en};
        REG_STATUS:  next_r.prdata = {26'h0, stat.sleep_deep, stat.busy, stat.state};
        REG_PENDING: next_r.prdata = {19'h0, stat.pending};
        REG_WAKES:   next_r.prdata = {16'h0, stat.wakes};
        default:     next_r.pslverr = 1'b1;
      endcase
    end
    if (wr && paddr == REG_CTRL) begin
      next_r.ctrl.go    = pwdata[CTRL_GO];
      next_r.ctrl.abort = pwdata[CTRL_ABORT];
    end
    if (wr && paddr == REG_SRC_EN) begin
      next_r.ctrl.src_en = pwdata[12:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{ctrl: '{go: 1'b0, abort: 1'b0, src_en: SRC_EN_RST}, prdata: 32'h0, pslverr: 1'b0};
    end else begin
      r <= next_r;
    end
  end
endmodule

/* File: hw/pdwg_host.sv */
// power-down wake-up gate controller: sweeps and clears device wake flags, then enters power-down
// assumes the device shows its power-down state on dev_in_pd, synchronous to pclk
`timescale 1ns/1ps
module pdwg_host import pdwg_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             m_psel,
  output logic             m_penable,
  output logic             m_pwrite,
  output logic      [31:0] m_paddr,
  output logic      [31:0] m_pwdata,
  input  wire logic        m_pready,
  input  wire logic [31:0] m_prdata,
  input  wire logic        dev_in_pd,
  output logic             sleep_deep,
  output logic             wfi_pulse
);
  // flag register of each source
  function automatic logic [31:0] src_addr(input logic [3:0] i);
    case (i)
      SRC_BOD:  src_addr = BOD_ADDR;
      SRC_GPIO: src_addr = GPIO_ADDR;
      SRC_TMR:  src_addr = TMR_ADDR;
      SRC_WDT:  src_addr = WDT_ADDR;
      SRC_RTC:  src_addr = RTC_ADDR;
      SRC_UART: src_addr = UART_ADDR;
      SRC_I2C:  src_addr = I2C_ADDR;
      SRC_USBH: src_addr = USBH_ADDR;
      SRC_USBD: src_addr = USBD_ADDR;
      SRC_OTG:  src_addr = OTG_ADDR;
      SRC_CAN:  src_addr = CAN_ADDR;
      SRC_TK:   src_addr = TK_ADDR;
      default:  src_addr = ACMP_ADDR;
    endcase
  endfunction

  function automatic logic [31:0] src_mask(input logic [3:0] i);
    case (i)
      SRC_BOD:  src_mask = BOD_MASK;
      SRC_GPIO: src_mask = GPIO_MASK;
      SRC_TMR:  src_mask = TMR_MASK;
      SRC_WDT:  src_mask = WDT_MASK;
      SRC_RTC:  src_mask = RTC_MASK;
      SRC_UART: src_mask = UART_MASK;
      SRC_I2C:  src_mask = I2C_MASK;
      SRC_USBH: src_mask = USBH_MASK;
      SRC_USBD: src_mask = USBD_MASK;
      SRC_OTG:  src_mask = OTG_MASK;
      SRC_CAN:  src_mask = CAN_MASK;
      SRC_TK:   src_mask = TK_MASK;
      default:  src_mask = ACMP_MASK;
    endcase
  endfunction

  // value that clears the set flags of a source without touching the others
  function automatic logic [31:0] src_clr(input logic [3:0] i, input logic [31:0] rd);
    if (i == SRC_CAN) begin
      src_clr = rd & ~src_mask(i);
    end else begin
      // write 1 to each set flag
      src_clr = rd & src_mask(i);
    end
  endfunction

  function automatic logic [31:0] key_val(input logic [1:0] k);
    case (k)
      2'h0:    key_val = KEY0;
      2'h1:    key_val = KEY1;
      default: key_val = KEY2;
    endcase
  endfunction

  typedef struct packed {
    pdwg_state_t st;
    logic [3:0]  idx;
    logic [1:0]  key;
    logic        unlocked;
    logic        issued;
    logic        req_valid;
    pdwg_req_t   req;
    logic [31:0] hold;
    logic [12:0] pending;
    logic [15:0] wakes;
    logic        sleep_deep;
    logic        wait_for_interrupt_instr;
  } pdwg_host_t;
  pdwg_host_t r, next_r;

  pdwg_ctrl_t  ctrl;
  pdwg_stat_t  stat;
  pdwg_apb_t   m;
  logic        req_ready;
  logic        m_done;
  logic [31:0] m_rdata;
  logic        flag_set;
  logic        last_src;

  assign stat       = '{state: r.st, busy: (r.st != ST_IDLE), sleep_deep: r.sleep_deep,
                        pending: r.pending, wakes: r.wakes};
  assign m_psel     = m.psel;
  assign m_penable  = m.penable;
  assign m_pwrite   = m.pwrite;
  assign m_paddr    = m.paddr;
  assign m_pwdata   = m.pwdata;
  assign sleep_deep = r.sleep_deep;
  assign wfi_pulse  = r.wait_for_interrupt_instr;
  assign flag_set   = (m_rdata & src_mask(r.idx)) != 32'h0000_0000;
  assign last_src   = r.idx == 4'(NSRC - 1);

  pdwg_apb_slave u_slave (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .stat    (stat),
    .ctrl    (ctrl)
  );

  pdwg_apb_master u_master (
    .pclk      (pclk),
    .presetn   (presetn),
    .req_valid (r.req_valid),
    .req       (r.req),
    .req_ready (req_ready),
    .done      (m_done),
    .rdata     (m_rdata),
    .m         (m),
    .m_pready  (m_pready),
    .m_prdata  (m_prdata)
  );

  always_comb begin
    next_r     = r;
    next_r.wait_for_interrupt_instr = 1'b0;
    if (r.req_valid && req_ready) begin
      next_r.req_valid = 1'b0;
    end
    case (r.st)
      ST_IDLE: begin
        if (ctrl.go) begin
          next_r.st       = ST_READ;
          next_r.idx      = 4'h0;
          next_r.pending  = 13'h0000;
          next_r.unlocked = 1'b0;
          next_r.issued   = 1'b0;
        end
      end
      ST_READ: begin
        if (!r.issued) begin
          if (!ctrl.src_en[r.idx]) begin
            next_r.st = ST_NEXT;
          end else begin
            next_r.req       = '{addr: src_addr(r.idx), write: 1'b0, wdata: 32'h0000_0000};
            next_r.req_valid = 1'b1;
            next_r.issued    = 1'b1;
          end
        end else if (m_done) begin
          next_r.issued = 1'b0;
          next_r.hold   = m_rdata;
          if (flag_set) begin
            next_r.pending[r.idx] = 1'b1;
            if (r.idx == SRC_WDT && !r.unlocked) begin
              next_r.st  = ST_UNLOCK;
              next_r.key = 2'h0;
            end else begin
              next_r.st = ST_CLEAR;
            end
          end else begin
            next_r.st = ST_NEXT;
          end
        end
      end
      ST_UNLOCK: begin
        if (!r.issued) begin
          next_r.req       = '{addr: LOCK_ADDR, write: 1'b1, wdata: key_val(r.key)};
          next_r.req_valid = 1'b1;
          next_r.issued    = 1'b1;
        end else if (m_done) begin
          next_r.issued = 1'b0;
          if (r.key == NKEY_LAST) begin
            next_r.unlocked = 1'b1;
            next_r.st       = ST_CLEAR;
          end else begin
            next_r.key = r.key + 2'h1;
          end
        end
      end
      ST_CLEAR: begin
        if (!r.issued) begin
          next_r.req       = '{addr: src_addr(r.idx), write: 1'b1,
                               wdata: src_clr(r.idx, r.hold)};
          next_r.req_valid = 1'b1;
          next_r.issued    = 1'b1;
        end else if (m_done) begin
          // read the flag back; move on only once it reads cleared
          next_r.issued = 1'b0;
          next_r.st     = ST_READ;
        end
      end
      ST_NEXT: begin
        if (last_src) begin
          next_r.st = ST_PWR;
        end else begin
          next_r.idx = r.idx + 4'h1;
          next_r.st  = ST_READ;
        end
      end
      ST_PWR: begin
        if (!r.issued) begin
          next_r.req        = '{addr: PWR_CTRL_ADDR, write: 1'b1, wdata: PWRDN_EN_MASK};
          next_r.req_valid  = 1'b1;
          next_r.issued     = 1'b1;
          next_r.sleep_deep = 1'b1;
        end else if (m_done) begin
          next_r.issued = 1'b0;
          next_r.st     = ST_WFI;
        end
      end
      ST_WFI: begin
        next_r.wait_for_interrupt_instr = 1'b1;
        next_r.st  = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (ctrl.abort) begin
          next_r.sleep_deep = 1'b0;
          next_r.st         = ST_IDLE;
        end else if (dev_in_pd) begin
          next_r.st = ST_AWAKE;
        end
      end
      ST_AWAKE: begin
        if (!dev_in_pd || ctrl.abort) begin
          next_r.wakes      = r.wakes + 16'h0001;
          next_r.sleep_deep = 1'b0;
          next_r.st         = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: ST_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // checks
  pwr_after_sweep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.req_valid && r.req.addr == PWR_CTRL_ADDR) |-> last_src && r.req.wdata[6])
    else $error("power-down enable written before sweep finished");

  recheck_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_CLEAR && r.issued && m_done) |=> r.st == ST_READ ##1 r.req_valid)
    else $error("flag not read back after clear");

  w1c_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.req_valid && r.req.write && r.st == ST_CLEAR && r.idx != SRC_CAN)
      |-> (r.req.wdata & src_mask(r.idx)) != 32'h0 && (r.req.wdata & ~src_mask(r.idx)) == 32'h0)
    else $error("clear write does not hit the set flags");

  can_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.req_valid && r.req.write && r.req.addr == CAN_ADDR) |-> !r.req.wdata[0])
    else $error("can wake status not cleared by zero");

  wdt_unlock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.req_valid && r.req.write && r.req.addr == WDT_ADDR) |-> r.unlocked)
    else $error("watchdog flag written while protected");

  pending_mark_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_READ && r.issued && m_done && flag_set) |=> r.pending[$past(r.idx)]
      && (r.st == ST_CLEAR || r.st == ST_UNLOCK))
    else $error("set flag not recorded");

  wfi_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.wait_for_interrupt_instr) |-> sleep_deep && $past(m_done, 2))
    else $error("wfi without power-down setup");

  wake_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_AWAKE && !dev_in_pd) |=> r.wakes == $past(r.wakes) + 16'h0001 && !sleep_deep)
    else $error("wake not counted");

  single_wfi_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.wait_for_interrupt_instr |=> !r.wait_for_interrupt_instr [*3])
    else $error("wfi pulse longer than one cycle");

  abort_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.abort && (r.st == ST_SLEEP || r.st == ST_AWAKE)) |=> r.st == ST_IDLE && !sleep_deep)
    else $error("abort did not leave the power-down wait");

  sleep_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_WFI || r.st == ST_SLEEP || r.st == ST_AWAKE) |-> sleep_deep)
    else $error("sleep enable dropped while waiting on the device");

  src_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_NEXT && !last_src) |=> r.st == ST_READ && r.idx == $past(r.idx) + 4'h1)
    else $error("sweep skipped a source");

  go_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_IDLE && ctrl.go) |=> r.st == ST_READ && r.idx == 4'h0 && r.pending == 13'h0000)
    else $error("sweep did not restart from the first source");

  idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ST_IDLE |-> !r.req_valid && !r.issued && !sleep_deep)
    else $error("idle controller still requesting or sleeping");

  clear_target_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == ST_CLEAR && r.req_valid) |-> r.req.write && r.req.addr == src_addr(r.idx))
    else $error("clear write aimed at the wrong register");

  read_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.req_valid && !r.req.write) |-> r.st == ST_READ)
    else $error("flag read issued outside the sweep");

  // main scenarios
  sweep_c: cover property (@(posedge pclk) disable iff (!presetn)
    r.st == ST_CLEAR && r.idx == SRC_CAN);
  unlock_c: cover property (@(posedge pclk) disable iff (!presetn)
    r.st == ST_UNLOCK ##1 r.st == ST_UNLOCK);
  sleep_c: cover property (@(posedge pclk) disable iff (!presetn)
    r.st == ST_SLEEP ##1 r.st == ST_AWAKE);
  abort_c: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl.abort && r.st == ST_AWAKE);
  wdt_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    r.st == ST_CLEAR && r.idx == SRC_WDT && r.unlocked);
endmodule

/* File: hw/pdwg_pkg.sv */
// constants, register map and carrier types of the power-down wake-up gate controller
// assumes one 200 MHz clock; the device is reached by an apb master, software by an apb slave
// How it works
// - power-down enable and wfi only after every enabled wake flag reads cleared
// - brown-out flag wakes; controller writes 1 to clear it before re-entry
// - gpio pin source bit wakes; controller writes 1 to clear it before re-entry
// - timer wakes; controller writes 1 to whichever of the timer wake and timer irq flags read set
// - watchdog wakes; wake flag cleared by writing 1 after lifting write protection
// - rtc alarm, tick and snoop flags wake; each cleared by writing 1
// - uart data and clear-to-send wake flags cleared by writing 1
// - serial bus falling edge wakes; its wake flag cleared by writing 1
// - usb host remote wake; port connect change bit cleared by writing 1
// - usb device remote wake; bus event flag cleared by writing 1
// - otg id pin change wakes; id change flag cleared by writing 1
// - can receive edge wakes; can wake status bit cleared by writing 0
// - touch key event wakes; touch key flag cleared by writing 1
// - comparator wake interrupt wakes; comparator wake flag cleared by writing 1
// - power-down entered after sleep enable, power-down enable and then wfi
package pdwg_pkg;
  localparam int         NSRC = 13;
  localparam logic [3:0] SRC_BOD = 4'h0, SRC_GPIO = 4'h1, SRC_TMR = 4'h2, SRC_WDT = 4'h3;
  localparam logic [3:0] SRC_RTC = 4'h4, SRC_UART = 4'h5, SRC_I2C = 4'h6, SRC_USBH = 4'h7;
  localparam logic [3:0] SRC_USBD = 4'h8, SRC_OTG = 4'h9, SRC_CAN = 4'hA, SRC_TK = 4'hB;
  localparam logic [3:0] SRC_ACMP = 4'hC;
  // device flag registers
  localparam logic [31:0] BOD_ADDR  = 32'h4000_0018, BOD_MASK  = 32'h0000_0010;
  localparam logic [31:0] GPIO_ADDR = 32'h4000_4020, GPIO_MASK = 32'h0000_0001;
  localparam logic [31:0] TMR_ADDR  = 32'h4005_0008, TMR_MASK  = 32'h0000_0003;
  localparam logic [31:0] WDT_ADDR  = 32'h4004_0000, WDT_MASK  = 32'h0000_0020;
  localparam logic [31:0] RTC_ADDR  = 32'h4004_102C, RTC_MASK  = 32'h0000_0007;
  localparam logic [31:0] UART_ADDR = 32'h4007_001C, UART_MASK = 32'h0003_0000;
  localparam logic [31:0] I2C_ADDR  = 32'h4008_0044, I2C_MASK  = 32'h0000_0001;
  localparam logic [31:0] USBH_ADDR = 32'h4000_9054, USBH_MASK = 32'h0001_0000;
  localparam logic [31:0] USBD_ADDR = 32'h400C_0004, USBD_MASK = 32'h0000_0001;
  localparam logic [31:0] OTG_ADDR  = 32'h4004_D00C, OTG_MASK  = 32'h0000_0002;
  localparam logic [31:0] CAN_ADDR  = 32'h400A_0168, CAN_MASK  = 32'h0000_0001;
  localparam logic [31:0] TK_ADDR   = 32'h400E_2004, TK_MASK   = 32'h0000_0001;
  localparam logic [31:0] ACMP_ADDR = 32'h4004_5008, ACMP_MASK = 32'h0000_0010;
  // power control register and its power_down_enable_bit (bit 6)
  localparam logic [31:0] PWR_CTRL_ADDR = 32'h4000_0200, PWRDN_EN_MASK = 32'h0000_0040;
  // write-protection unlock; key values are arbitrary
  localparam logic [31:0] LOCK_ADDR = 32'h4000_0100;
  localparam logic [31:0] KEY0 = 32'h0000_00A1, KEY1 = 32'h0000_00B2, KEY2 = 32'h0000_00C3;
  localparam logic [1:0]  NKEY_LAST = 2'h2;
  // own register map
  localparam logic [7:0]  REG_CTRL = 8'h00, REG_SRC_EN = 8'h04, REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_PENDING = 8'h0C, REG_WAKES = 8'h10;
  localparam logic [12:0] SRC_EN_RST = 13'h1FFF;
  localparam int          CTRL_GO = 0, CTRL_ABORT = 1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_READ = 4'h1, ST_UNLOCK = 4'h3, ST_CLEAR = 4'h2, ST_NEXT = 4'h6,
    ST_PWR = 4'h7, ST_WFI = 4'h5, ST_SLEEP = 4'h4, ST_AWAKE = 4'hC
  } pdwg_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [31:0] wdata;
  } pdwg_req_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pdwg_apb_t;

  typedef struct packed {
    logic        go;
    logic        abort;
    logic [12:0] src_en;
  } pdwg_ctrl_t;

  typedef struct packed {
    pdwg_state_t state;
    logic        busy;
    logic        sleep_deep;
    logic [12:0] pending;
    logic [15:0] wakes;
  } pdwg_stat_t;
endpackage

/* File: tb/pdwg_dev_model.sv */
// device model: wake flag registers, key unlock, power-down entry and wake-up
// assumes an apb master on pclk that holds each request until it samples pready
`timescale 1ns/1ps
module pdwg_dev_model import pdwg_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  input  wire logic        sleep_deep,
  input  wire logic        wfi_pulse,
  output logic             in_pd,
  input  wire logic [12:0] wake_set,
  output logic      [12:0] flag_set
);
  localparam logic [31:0] ADR [NSRC] = '{BOD_ADDR, GPIO_ADDR, TMR_ADDR, WDT_ADDR, RTC_ADDR,
    UART_ADDR, I2C_ADDR, USBH_ADDR, USBD_ADDR, OTG_ADDR, CAN_ADDR, TK_ADDR, ACMP_ADDR};
  localparam logic [31:0] MSK [NSRC] = '{BOD_MASK, GPIO_MASK, TMR_MASK, WDT_MASK, RTC_MASK,
    UART_MASK, I2C_MASK, USBH_MASK, USBD_MASK, OTG_MASK, CAN_MASK, TK_MASK, ACMP_MASK};
  localparam logic [31:0] KEY [4] = '{KEY0, KEY1, KEY2, KEY2};
  logic [31:0] regs [NSRC];  // kept through power-down
  logic [1:0]  wait_c;
  logic [1:0]  key_st;
  logic        pwrdn_set;
  logic        hold;
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      flag_set[i] = |(regs[i] & MSK[i]);
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      foreach (regs[i]) regs[i] <= '0;
      {wait_c, key_st, pwrdn_set, hold, in_pd, pready} <= '0;
      prdata <= '0;
    end else begin
      pready <= 1'b0;
      // an idle read bus inverts its last data every cycle
      prdata <= ~prdata;
      if (psel && penable && !pready) begin
        if (wait_c != 2'h0) wait_c <= wait_c - 2'h1;
        else begin
          pready <= 1'b1;
          wait_c <= 2'($urandom_range(2));
          prdata <= (paddr == PWR_CTRL_ADDR) ? {25'h0, pwrdn_set, 6'h0} : 32'h0;
          for (int i = 0; i < NSRC; i++) begin
            if (paddr == ADR[i]) prdata <= regs[i];
          end
        end
      end
      if (psel && penable && pready && pwrite) begin
        if (paddr == LOCK_ADDR)
          key_st <= (pwdata == KEY[key_st] && key_st != 2'h3) ? key_st + 2'h1 : 2'h0;
        if (paddr == PWR_CTRL_ADDR) pwrdn_set <= |(pwdata & PWRDN_EN_MASK);
        for (int i = 0; i < NSRC; i++) begin
          if (paddr == ADR[i] && i == int'(SRC_CAN))
            regs[i] <= regs[i] & (pwdata | ~MSK[i]);
          else if (paddr == ADR[i] && (i != int'(SRC_WDT) || key_st == 2'h3))
            regs[i] <= regs[i] & ~(pwdata & MSK[i]);
        end
      end
      // set wins: a wake in the same cycle as a clear keeps its flag
      for (int i = 0; i < NSRC; i++) begin
        if (wake_set[i]) regs[i] <= regs[i] | MSK[i];
      end
      if (wfi_pulse && sleep_deep && pwrdn_set) begin
        {in_pd, hold} <= 2'h3;
        pwrdn_set <= 1'b0;
        key_st <= 2'h0;
      end else if (in_pd) begin
        hold <= 1'b0;
        if (!hold && (|flag_set || |wake_set)) in_pd <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/test_power_down_wakeup_gate.sv */
// self-checking bench for the wake-up gate controller
// assumes the device model on the master side and apb access from this bench
`timescale 1ns/1ps
module test_power_down_wakeup_gate;
  import pdwg_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] wake_set = 13'h0;
  logic [31:0] prdata, m_paddr, m_pwdata, m_prdata;
  logic        pready, pslverr, m_psel, m_penable, m_pwrite, m_pready;
  logic        in_pd, sleep_deep, wfi_pulse;
  logic [12:0] flag_set;
  int          n_errors = 0;
  int          cmp_count = 0;
  always #2.5 pclk = ~pclk;
  pdwg_host u_pdwg_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite),
    .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_pready(m_pready), .m_prdata(m_prdata),
    .dev_in_pd(in_pd), .sleep_deep(sleep_deep), .wfi_pulse(wfi_pulse));
  pdwg_dev_model u_pdwg_dev_model (.pclk(pclk), .presetn(presetn), .psel(m_psel),
    .penable(m_penable), .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata),
    .pready(m_pready), .prdata(m_prdata), .sleep_deep(sleep_deep), .wfi_pulse(wfi_pulse),
    .in_pd(in_pd), .wake_set(wake_set), .flag_set(flag_set));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic pulse_wake(input logic [12:0] w);
    @(posedge pclk);
    wake_set <= w;
    @(posedge pclk);
    wake_set <= 13'h0;
  endtask
  initial begin
    logic [31:0] q;
    logic        e;
    logic [12:0] en, fl, cur, w;
    int          k, nw;
    void'($urandom(24));
    cur = 13'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_SRC_EN, 32'h0, q, e);
    check(q, {19'h0, SRC_EN_RST});
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    check(q, 32'h0);
    apb(1'b1, REG_PENDING, 32'h1FFF, q, e);
    apb(1'b0, REG_PENDING, 32'h0, q, e);
    check(q, 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    $display("test reset done");
    for (int it = 0; it < 10; it++) begin
      // corners first: all sources, the write-zero source alone, disabled sources left set
      en = (it < 2) ? 13'h1FFF : (it == 2) ? 13'h0FF0 : 13'($urandom);
      fl = (it == 1) ? 13'h0400 : (it < 3) ? 13'h1FFF : 13'($urandom);
      pulse_wake(fl);
      cur = cur | fl;
      apb(1'b1, REG_SRC_EN, {19'h0, en}, q, e);
      apb(1'b1, REG_CTRL, 32'h1, q, e);
      nw = 0;
      for (k = 0; k < 5000 && in_pd !== 1'b1; k++) begin
        @(negedge pclk);
        nw += int'(wfi_pulse === 1'b1);
      end
      if (k >= 5000) begin
        n_errors++;
        finish_test();
      end
      check(32'(nw), 32'h1);
      check({31'h0, sleep_deep}, 32'h1);
      check({19'h0, flag_set}, {19'h0, cur & ~en});
      apb(1'b0, REG_PENDING, 32'h0, q, e);
      check(q, {19'h0, cur & en});
      cur = cur & ~en;
      w = 13'h1 << $urandom_range(12);
      pulse_wake(w);
      cur = cur | w;
      for (k = 0; k < 200; k++) begin
        apb(1'b0, REG_STATUS, 32'h0, q, e);
        if (q[4] === 1'b0) break;
      end
      if (k >= 200) begin
        n_errors++;
        finish_test();
      end
      apb(1'b0, REG_WAKES, 32'h0, q, e);
      check(q, 32'(it + 1));
      check({31'h0, sleep_deep}, 32'h0);
      $display("test sweep %0d done", it);
    end
    // abort while the device still sleeps: every flag swept, nothing left to wake it
    apb(1'b1, REG_SRC_EN, 32'h0000_1FFF, q, e);
    apb(1'b1, REG_CTRL, 32'h0000_0001, q, e);
    for (k = 0; k < 5000 && in_pd !== 1'b1; k++) @(negedge pclk);
    if (k >= 5000) begin
      n_errors++;
      finish_test();
    end
    repeat (4) @(posedge pclk);
    apb(1'b1, REG_CTRL, 32'h0000_0002, q, e);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    check(q, 32'h0);
    apb(1'b0, REG_WAKES, 32'h0, q, e);
    check(q, 32'h0000_000B);
    check({31'h0, in_pd}, 32'h1);
    check({19'h0, flag_set}, 32'h0);
    $display("test abort done");
    finish_test();
  end
endmodule
